//--- core/pchr_cfg_regs.sv
// Purpose: Command low bits, class/revision and header/latency words
// Assumes: Configuration decode done upstream, one access per strobe
// Notes:   Read data is registered, one cycle after the read strobe
`include "pchr_consts.svh"

module pchr_cfg_regs #(
  parameter logic [3:0] DIE_ID  = 4'h3, // Arbitrary value
  parameter logic [3:0] REV_NUM = 4'h0
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // Configuration access
  input  wire logic        CFG_SEL,
  input  wire logic        CFG_RD,
  input  wire logic        CFG_WR,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE_B,
  input  wire logic [31:0] CFG_WDATA,
  output logic      [31:0] CFG_RDATA,
  output logic             CFG_RVALID,
  // Target side
  input  wire logic        TGT_MEM_HIT,
  input  wire logic        TGT_IO_HIT,
  input  wire logic        TGT_SPECIAL,
  input  wire logic        TGT_PAR_ERR,
  output logic             TGT_MEM_CLAIM,
  output logic             TGT_IO_CLAIM,
  output logic             TGT_SPECIAL_ACK,
  output logic             PERR_REPORT,
  // Master side
  input  wire logic        MST_REQ,
  input  wire logic        MST_FRAME_START,
  input  wire logic        MST_ACTIVE,
  input  wire logic        GNT_B,
  output logic             MST_GO,
  output logic      [3:0]  MST_WR_CMD,
  output logic             MST_RELEASE,
  // Status
  output logic             MEM_SPACE_EN,
  output logic             BUS_MASTER_EN,
  output logic             PERR_RESP_EN,
  output logic      [7:0]  LAT_CLKS
);

  // ****************************************************
  // Decode helpers
  // ****************************************************
  function automatic logic lane_wr(input logic [3:0] be_b,
                                   input int         lane);
    lane_wr = ~be_b[lane];
  endfunction : lane_wr

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  // ****************************************************
  // Register state
  // ****************************************************
  logic                  perr_q, perr_d;
  logic                  mem_q, mem_d;
  logic                  mst_q, mst_d;
  logic [`PCHR_LT_W-1:0] lt_q, lt_d;
  logic [31:0]           rdata_q, rdata_d;
  logic                  rvalid_q, rvalid_d;
  logic                  wr_en;
  logic                  rd_en;

  assign wr_en = CFG_SEL & CFG_WR;
  assign rd_en = CFG_SEL & CFG_RD;

  always_comb begin
    perr_d   = perr_q;
    mem_d    = mem_q;
    mst_d    = mst_q;
    lt_d     = lt_q;
    rdata_d  = rdata_q;
    rvalid_d = rd_en;
    if (wr_en && hit(CFG_ADDR, `PCHR_OFF_CMD) &&
        lane_wr(CFG_BE_B, `PCHR_LANE_CMD)) begin
      perr_d = CFG_WDATA[`PCHR_CMD_PERR];
      mst_d  = CFG_WDATA[`PCHR_CMD_MASTER];
      mem_d  = CFG_WDATA[`PCHR_CMD_MEM];
    end
    if (wr_en && hit(CFG_ADDR, `PCHR_OFF_HDR) &&
        lane_wr(CFG_BE_B, `PCHR_LANE_LT)) begin
      lt_d = CFG_WDATA[`PCHR_LT_HI:`PCHR_LT_LO];
    end
    if (rd_en) begin
      rdata_d = 32'h0000_0000;
      if (hit(CFG_ADDR, `PCHR_OFF_CMD)) begin
        rdata_d[`PCHR_CMD_PERR]   = perr_q;
        rdata_d[`PCHR_CMD_MASTER] = mst_q;
        rdata_d[`PCHR_CMD_MEM]    = mem_q;
      end else if (hit(CFG_ADDR, `PCHR_OFF_CLASS)) begin
        rdata_d = {`PCHR_BASE_CLASS, `PCHR_SUB_CLASS, `PCHR_PROG_IF,
                   DIE_ID, REV_NUM};
      end else if (hit(CFG_ADDR, `PCHR_OFF_HDR)) begin
        rdata_d[`PCHR_HDR_HI:`PCHR_HDR_LO] = `PCHR_HDR_TYPE;
        rdata_d[`PCHR_LT_HI:`PCHR_LT_LO] = lt_q;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      perr_q   <= 1'b0;
      mem_q    <= 1'b0;
      mst_q    <= 1'b0;
      lt_q     <= '0;
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      perr_q   <= perr_d;
      mem_q    <= mem_d;
      mst_q    <= mst_d;
      lt_q     <= lt_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign CFG_RDATA     = rdata_q;
  assign CFG_RVALID    = rvalid_q;
  assign MEM_SPACE_EN  = mem_q;
  assign BUS_MASTER_EN = mst_q;
  assign PERR_RESP_EN  = perr_q;
  // Timer granularity is eight clocks, low bits fixed
  assign LAT_CLKS      = {lt_q, `PCHR_LT_PAD};

  // ****************************************************
  // Target gating
  // ****************************************************
  // Claim memory only when enabled
  assign TGT_MEM_CLAIM   = TGT_MEM_HIT & mem_q;
  assign TGT_IO_CLAIM    = TGT_IO_HIT & 1'b0;
  assign TGT_SPECIAL_ACK = TGT_SPECIAL & 1'b0;
  assign PERR_REPORT     = TGT_PAR_ERR & perr_q;

  // ****************************************************
  // Master tenure
  // ****************************************************
  pchr_pkg::pchr_tenure_t  st_q, st_d;
  logic [`PCHR_CNT_W-1:0]  cnt_q, cnt_d;
  logic                    expired;

  assign expired = (cnt_q >= LAT_CLKS);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      pchr_pkg::PCHR_IDLE: begin
        if (MST_FRAME_START && mst_q) begin
          st_d  = pchr_pkg::PCHR_OWN;
          cnt_d = `PCHR_CNT_ONE;
        end
      end
      pchr_pkg::PCHR_OWN: begin
        if (!MST_ACTIVE) begin
          st_d  = pchr_pkg::PCHR_IDLE;
          cnt_d = '0;
        end else if (cnt_q != `PCHR_CNT_MAX) begin
          cnt_d = cnt_q + `PCHR_CNT_ONE;
        end
      end
      default: begin
        st_d  = pchr_pkg::PCHR_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q  <= pchr_pkg::PCHR_IDLE;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign MST_GO      = MST_REQ & mst_q;
  assign MST_WR_CMD  = `PCHR_MEM_WR_CMD;
  assign MST_RELEASE = (st_q == pchr_pkg::PCHR_OWN) & expired & GNT_B;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  AST_CMD_RB: assert property (
    rd_en && hit(CFG_ADDR, `PCHR_OFF_CMD) |=>
      CFG_RVALID && CFG_RDATA[7] == 1'b0 && CFG_RDATA[5:3] == 3'h0 &&
      CFG_RDATA[0] == 1'b0 && CFG_RDATA[6] == $past(perr_q))
    else $error("Command read-back wrong");
  AST_PERR_GATE: assert property (
    !PERR_RESP_EN |-> !PERR_REPORT)
    else $error("Parity reported while response off");
  AST_MEM_WR: assert property (
    wr_en && hit(CFG_ADDR, `PCHR_OFF_CMD) && !CFG_BE_B[0] |=>
      MEM_SPACE_EN == $past(CFG_WDATA[`PCHR_CMD_MEM]))
    else $error("Memory space bit not stored");
  AST_CLAIM: assert property (
    TGT_MEM_CLAIM |-> MEM_SPACE_EN && TGT_MEM_HIT)
    else $error("Memory cycle claimed while disabled");
  AST_NO_IO: assert property (
    !TGT_IO_CLAIM && !TGT_SPECIAL_ACK)
    else $error("I/O or special cycle claimed");
  AST_GO: assert property (
    MST_GO |-> BUS_MASTER_EN)
    else $error("Master start while disabled");
  AST_CMD: assert property (
    MST_WR_CMD == `PCHR_MEM_WR_CMD)
    else $error("Write command not plain memory write");
  AST_CLASS: assert property (
    rd_en && hit(CFG_ADDR, `PCHR_OFF_CLASS) |=>
      CFG_RDATA == {`PCHR_BASE_CLASS, `PCHR_SUB_CLASS, `PCHR_PROG_IF,
                    DIE_ID, REV_NUM})
    else $error("Class word wrong");
  AST_HDR: assert property (
    rd_en && hit(CFG_ADDR, `PCHR_OFF_HDR) |=>
      CFG_RDATA[31:16] == 16'h0000 && CFG_RDATA[10:0] == 11'h000)
    else $error("Header word fixed bits wrong");
  AST_MIN_SLOT: assert property (
    st_q == pchr_pkg::PCHR_OWN && cnt_q < LAT_CLKS |->
      !MST_RELEASE)
    else $error("Released before minimum slot");

  COV_CLAIM:   cover property (TGT_MEM_CLAIM);
  COV_RELEASE: cover property (MST_RELEASE);
  COV_PERR:    cover property (PERR_REPORT);

endmodule : pchr_cfg_regs

//--- core/pchr_consts.svh
// Purpose: Constants for the configuration header register slice
// Assumes: Byte addresses on the configuration port, 32-bit words
// Notes:   Shared by the package users and the register module
`ifndef PCHR_CONSTS_SVH
`define PCHR_CONSTS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define PCHR_OFF_CMD      8'h04
`define PCHR_OFF_CLASS    8'h08
`define PCHR_OFF_HDR      8'h0C

// ****************************************************
// Command field bit positions
// ****************************************************
`define PCHR_CMD_PERR     6
`define PCHR_CMD_MASTER   2
`define PCHR_CMD_MEM      1

// ****************************************************
// Byte lanes and header field position
// ****************************************************
`define PCHR_LANE_CMD     0
`define PCHR_LANE_LT      1
`define PCHR_HDR_HI       23
`define PCHR_HDR_LO       16

// ****************************************************
// Fixed field values and positions
// ****************************************************
`define PCHR_BASE_CLASS   8'h02
`define PCHR_SUB_CLASS    8'h80
`define PCHR_PROG_IF      8'h00
`define PCHR_HDR_TYPE     8'h00
`define PCHR_LT_HI        15
`define PCHR_LT_LO        11
`define PCHR_LT_W         5
`define PCHR_LT_PAD       3'h0
`define PCHR_MEM_WR_CMD   4'h7
`define PCHR_CNT_W        8
`define PCHR_CNT_ONE      8'h01
`define PCHR_CNT_MAX      8'hFF

`endif

//--- core/pchr_pkg.sv
// Purpose: Types for the configuration header register slice
// Assumes: Nothing beyond the constants header
// Notes:   Types only, constants live in the header
package pchr_pkg;

  typedef enum logic {
    PCHR_IDLE,
    PCHR_OWN
  } pchr_tenure_t;

endpackage : pchr_pkg

//--- testbench/pchr_host_model.sv
// Purpose: Host bridge issuing configuration cycles to the register slice
// Assumes: Requests launched 1 ns after the rising clock edge
// Notes:   Idle write data shows the inverse of the last value driven
module pchr_host_model (
  // Clock
  input  wire logic        clk,
  // Configuration port
  output logic             sel,
  output logic             rd,
  output logic             wr,
  output logic [7:0]       addr,
  output logic [3:0]       be_b,
  output logic [31:0]      wdata,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sel   = 1'b0;
    rd    = 1'b0;
    wr    = 1'b0;
    addr  = 8'h00;
    be_b  = 4'hF;
    wdata = 32'h0000_0000;
  end

  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d);
    @(posedge clk);
    #1;
    sel   = 1'b1;
    wr    = 1'b1;
    addr  = a;
    be_b  = be;
    wdata = d;
    @(posedge clk);
    #1;
    sel   = 1'b0;
    wr    = 1'b0;
    wdata = ~d;
  endtask : cfg_wr

  // Answer is waited for under a bound, never open-ended
  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d,
                        output bit ok);
    ok = 1'b0;
    d  = 32'h0000_0000;
    @(posedge clk);
    #1;
    sel  = 1'b1;
    rd   = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    sel = 1'b0;
    rd  = 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d  = rdata;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask : cfg_rd
endmodule : pchr_host_model

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the configuration register slice
// Assumes: Host model drives config cycles, bench drives bus events
// Notes:   Table rows first, then bus gating, tenure and reset cases
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_b   = 1'b0;
  logic sel, rd, wr, rv, mh, ih, sp, pe, mc, ic, sa, pr, rq, fs, ac, gb;
  logic go, rl, me, bm, pen;
  logic [7:0]  addr, lat;
  logic [3:0]  be_b, wcmd;
  logic [31:0] wd, rdat, d;
  logic [75:0] rows [6];
  int fails  = 0;
  int checks = 0;
  bit ok;

  always #25 ref_clk = ~ref_clk;

  pchr_host_model i_pchr_host_model (.clk(ref_clk), .sel(sel), .rd(rd),
    .wr(wr), .addr(addr), .be_b(be_b), .wdata(wd), .rdata(rdat),
    .rvalid(rv));

  pchr_cfg_regs i_pchr_cfg_regs (.REF_CLK(ref_clk), .RST_B(rst_b),
    .CFG_SEL(sel), .CFG_RD(rd), .CFG_WR(wr), .CFG_ADDR(addr),
    .CFG_BE_B(be_b), .CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_RVALID(rv),
    .TGT_MEM_HIT(mh), .TGT_IO_HIT(ih), .TGT_SPECIAL(sp), .TGT_PAR_ERR(pe),
    .TGT_MEM_CLAIM(mc), .TGT_IO_CLAIM(ic), .TGT_SPECIAL_ACK(sa),
    .PERR_REPORT(pr), .MST_REQ(rq), .MST_FRAME_START(fs), .MST_ACTIVE(ac),
    .GNT_B(gb), .MST_GO(go), .MST_WR_CMD(wcmd), .MST_RELEASE(rl),
    .MEM_SPACE_EN(me), .BUS_MASTER_EN(bm), .PERR_RESP_EN(pen),
    .LAT_CLKS(lat));

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    i_pchr_host_model.cfg_rd(a, d, ok);
    if (!ok) begin
      fails++;
      report_and_stop();
    end
    `CHK("read data", ex, d)
  endtask : rd_chk

  // Tenure: start a frame, then count edges with grant withdrawn
  task automatic frame_start;
    @(posedge ref_clk);
    #1;
    fs = 1'b1;
    ac = 1'b1;
    gb = 1'b1;
    @(posedge ref_clk);
    #1;
    fs = 1'b0;
  endtask : frame_start

  initial begin
    {mh, ih, sp, pe, rq, fs, ac} = 7'h00;
    gb = 1'b0;
    rows = '{{8'h04, 4'h0, 32'hFFFF_FFFF, 32'h0000_0046},
             {8'h04, 4'hF, 32'h0000_0000, 32'h0000_0046},
             {8'h08, 4'h0, 32'hFFFF_FFFF, 32'h0280_0030},
             {8'h0C, 4'h0, 32'hFFFF_FFFF, 32'h0000_F800},
             {8'h0C, 4'hD, 32'h0000_0800, 32'h0000_0800},
             {8'h10, 4'h0, 32'hFFFF_FFFF, 32'h0000_0000}};
    repeat (10) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    foreach (rows[i]) begin
      i_pchr_host_model.cfg_wr(rows[i][75:68], rows[i][67:64],
                               rows[i][63:32]);
      rd_chk(rows[i][75:68], rows[i][31:0]);
    end
    `CHK("lat clks", 8'h08, lat)
    `CHK("enables", 3'h7, {me, bm, pen})
    {mh, ih, sp, pe, rq} = 5'h1F;
    #1;
    `CHK("mem claim", 1'b1, mc)
    `CHK("io claim", 1'b0, ic)
    `CHK("special ack", 1'b0, sa)
    `CHK("perr report", 1'b1, pr)
    `CHK("master go", 1'b1, go)
    `CHK("write cmd", 4'h7, wcmd)
    frame_start();
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("release early", 1'b0, rl)
    @(posedge ref_clk);
    #1;
    `CHK("release at bound", 1'b1, rl)
    gb = 1'b0;
    ac = 1'b0;
    #1;
    `CHK("release with grant", 1'b0, rl)
    i_pchr_host_model.cfg_wr(8'h04, 4'h0, 32'h0000_0000);
    #1;
    `CHK("gated outputs", 3'h0, {mc, pr, go})
    frame_start();
    repeat (9) @(posedge ref_clk);
    #1;
    `CHK("no tenure", 1'b0, rl)
    ac = 1'b0;
    i_pchr_host_model.cfg_wr(8'h04, 4'h0, 32'h0000_0046);
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h0C, 32'h0000_0000);
    `CHK("claims after reset", 3'h0, {mc, pr, go})
    report_and_stop();
  end
endmodule : tb_top
